/* File: bcs_bank.v */
// two-slot control and status register bank with byte-wide register port
`timescale 1ns/1ps
`include "bcs_regs.vh"

module bcs_bank (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       power_on_reset_i,
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_rvalid_o,
  input  wire       security_capability_i,
  input  wire [1:0] serial_bus_present_in_n_i,
  input  wire [1:0] usb_present_in_n_i,
  input  wire [1:0] removal_request_in_n_i,
  input  wire [1:0] security_lock_in_n_i,
  output wire [1:0] power_enable_out_o,
  output wire [1:0] actual_slot_state0_o,
  output wire [2:0] actual_slot_state_b0_o,
  output wire [2:0] actual_slot_state_b1_o,
  output wire       alert_out_o
);

  // --------------------------------------------------------------------------
  // slot state codes and control reset byte
  // --------------------------------------------------------------------------
  // one-hot inside; a stray pattern falls to the decoders' default arm
  localparam [4:0] SL_EMPTY    = 5'h01;
  localparam [4:0] SL_INSERTED = 5'h02;
  localparam [4:0] SL_ENABLED  = 5'h04;
  localparam [4:0] SL_REM_REQ  = 5'h08;
  localparam [4:0] SL_REM_ALW  = 5'h10;
  localparam [7:0] CTRL_RST    = `BCS_CONTROL_RST;

  // --------------------------------------------------------------------------
  // pin synchronisation
  // --------------------------------------------------------------------------
  wire [7:0] pins_s;

  bcs_sync #(
    .W (8)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({security_lock_in_n_i, removal_request_in_n_i, usb_present_in_n_i, serial_bus_present_in_n_i}),
    .sync_o  (pins_s)
  );

  // --------------------------------------------------------------------------
  // per-slot logic
  // --------------------------------------------------------------------------
  wire [15:0] ctrl_byte_w;
  wire [15:0] stat_byte_w;
  wire [5:0]  ff_w;
  wire [5:0]  state_w;
  wire [1:0]  alert_w;
  wire [1:0]  alert_d_w;
  wire [1:0]  pwr_w;

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_slot
      wire [7:0] ctrl_ofs = (b == 0) ? `BCS_SLOT0_CONTROL_OFS : `BCS_SLOT1_CONTROL_OFS;
      wire [7:0] stat_ofs = (b == 0) ? `BCS_SLOT0_STATUS_OFS : `BCS_SLOT1_STATUS_OFS;

      wire sb_n   = pins_s[b];
      wire usb_n  = pins_s[2 + b];
      wire rreq_n = pins_s[4 + b];
      wire sec_n  = pins_s[6 + b];

      reg       lock_q;
      reg [2:0] req_q;
      reg       rreq_en_q;
      reg       schg_en_q;
      reg       wake_en_q;
      reg       pwr_q;
      reg [4:0] state_q;
      reg [2:0] code_q;
      reg       alert_q;
      reg       rreq_flag_q;
      reg       schg_flag_q;
      reg       present_prev_q;
      reg       rreq_prev_q;
      reg [2:0] ff_q;
      reg       ff_locked_q;

      reg       lock_d;
      reg [2:0] req_d;
      reg       rreq_en_d;
      reg       schg_en_d;
      reg       wake_en_d;
      reg       pwr_d;
      reg [4:0] state_d;
      reg [2:0] code_d;
      reg [4:0] req_onehot;
      reg       rreq_flag_d;
      reg       schg_flag_d;

      // device present when either active-low presence pin is low
      wire present = ~sb_n | ~usb_n;
      wire ins_evt = present & ~present_prev_q;
      wire rem_evt = ~present & present_prev_q;
      wire rreq_fall = ~rreq_n & rreq_prev_q;

      wire ctrl_wr  = reg_wr_i & (reg_addr_i == ctrl_ofs);
      wire stat_wr0 = reg_wr_i & (reg_addr_i == stat_ofs);
      wire stat_wr1 = reg_wr_i & (reg_addr_i == stat_ofs + 8'h01);

      wire [2:0] wr_req = reg_wdata_i[`BCS_CTL_REQ_HI:`BCS_CTL_REQ_LO];
      wire req_valid = (wr_req >= `BCS_ST_INSERTED) & (wr_req <= `BCS_ST_REM_ALLOWED);

      // removal request event: new press while enabled, or enabling over a pending flag
      wire rreq_evt = (rreq_fall & rreq_en_q)
                    | (ctrl_wr & reg_wdata_i[`BCS_CTL_RREQ_EN_BIT] & ~rreq_en_q & rreq_flag_q);

      // removal from the allowed state is masked only when wake enable is clear
      wire rem_masked = ~wake_en_q & (state_q == SL_REM_ALW);

      // ----------------------------------------------------------------------
      // slot state coding
      // ----------------------------------------------------------------------
      // reserved request codes decode to empty; req_valid keeps them from moving the state
      always @* begin
        case (wr_req)
          `BCS_ST_INSERTED:      req_onehot = SL_INSERTED;
          `BCS_ST_ENABLED:       req_onehot = SL_ENABLED;
          `BCS_ST_REM_REQUESTED: req_onehot = SL_REM_REQ;
          `BCS_ST_REM_ALLOWED:   req_onehot = SL_REM_ALW;
          default:               req_onehot = SL_EMPTY;
        endcase
      end

      always @* begin
        lock_d      = lock_q;
        req_d       = req_q;
        rreq_en_d   = rreq_en_q;
        schg_en_d   = schg_en_q;
        wake_en_d   = wake_en_q;
        pwr_d       = pwr_q;
        state_d     = state_q;
        rreq_flag_d = rreq_flag_q;
        schg_flag_d = schg_flag_q;

        if (ctrl_wr) begin
          lock_d    = reg_wdata_i[`BCS_CTL_LOCK_BIT];
          rreq_en_d = reg_wdata_i[`BCS_CTL_RREQ_EN_BIT];
          schg_en_d = reg_wdata_i[`BCS_CTL_SCHG_EN_BIT];
          wake_en_d = reg_wdata_i[`BCS_CTL_WAKE_EN_BIT];
          // the new lock value counts, so lock and power may go up together
          pwr_d = reg_wdata_i[`BCS_CTL_PWR_BIT] & present & reg_wdata_i[`BCS_CTL_LOCK_BIT];
          if (wr_req != `BCS_ST_EMPTY) begin
            req_d = wr_req;
          end
        end

        // sticky flags: hardware set wins over a write-one clear
        if (stat_wr0 & reg_wdata_i[`BCS_STS_RREQ_BIT]) begin
          rreq_flag_d = 1'b0;
        end
        if (rreq_fall) begin
          rreq_flag_d = 1'b1;
        end
        if (stat_wr0 & reg_wdata_i[`BCS_STS_SCHG_BIT]) begin
          schg_flag_d = 1'b0;
        end
        if (ins_evt | (rem_evt & ~rem_masked)) begin
          schg_flag_d = 1'b1;
        end

        // slot state, removal first
        if (rem_evt) begin
          state_d = SL_EMPTY;
          req_d   = `BCS_ST_EMPTY;
          pwr_d   = 1'b0;
        end else if (ins_evt & schg_en_q) begin
          state_d = SL_INSERTED;
        end else if (rreq_evt & present) begin
          state_d = SL_REM_ALW;
        end else if (ctrl_wr & present & req_valid) begin
          state_d = req_onehot;
        end
      end

      // code kept in a flop beside the one-hot state, so the outputs come from flops
      always @* begin
        case (state_d)
          SL_INSERTED: code_d = `BCS_ST_INSERTED;
          SL_ENABLED:  code_d = `BCS_ST_ENABLED;
          SL_REM_REQ:  code_d = `BCS_ST_REM_REQUESTED;
          SL_REM_ALW:  code_d = `BCS_ST_REM_ALLOWED;
          default:     code_d = `BCS_ST_EMPTY;
        endcase
      end

      wire alert_d = (schg_flag_d & schg_en_d) | (rreq_flag_d & rreq_en_d);

      always @(posedge clk_i) begin
        if (reset_i) begin
          lock_q         <= CTRL_RST[`BCS_CTL_LOCK_BIT];
          req_q          <= CTRL_RST[`BCS_CTL_REQ_HI:`BCS_CTL_REQ_LO];
          rreq_en_q      <= CTRL_RST[`BCS_CTL_RREQ_EN_BIT];
          schg_en_q      <= CTRL_RST[`BCS_CTL_SCHG_EN_BIT];
          wake_en_q      <= CTRL_RST[`BCS_CTL_WAKE_EN_BIT];
          pwr_q          <= CTRL_RST[`BCS_CTL_PWR_BIT];
          state_q        <= SL_EMPTY;
          code_q         <= `BCS_STATE_RST;
          alert_q        <= 1'b0;
          rreq_flag_q    <= 1'b0;
          schg_flag_q    <= 1'b0;
          present_prev_q <= 1'b0;
          rreq_prev_q    <= 1'b1;
        end else begin
          lock_q         <= lock_d;
          req_q          <= req_d;
          rreq_en_q      <= rreq_en_d;
          schg_en_q      <= schg_en_d;
          wake_en_q      <= wake_en_d;
          pwr_q          <= pwr_d;
          state_q        <= state_d;
          code_q         <= code_d;
          alert_q        <= alert_d;
          rreq_flag_q    <= rreq_flag_d;
          schg_flag_q    <= schg_flag_d;
          present_prev_q <= present;
          rreq_prev_q    <= rreq_n;
        end
      end

      // form factor lives outside reset_i; only power-on re-arms the write
      always @(posedge clk_i) begin
        if (power_on_reset_i) begin
          ff_q        <= `BCS_FF_POR;
          ff_locked_q <= 1'b0;
        end else if (stat_wr1 & ~ff_locked_q) begin
          ff_q        <= reg_wdata_i[`BCS_STS_FF_HI:`BCS_STS_FF_LO];
          ff_locked_q <= 1'b1;
        end
      end

      assign ctrl_byte_w[8*b +: 8] = {lock_q, req_q, rreq_en_q, schg_en_q, wake_en_q, pwr_q};
      assign stat_byte_w[8*b +: 8] = {security_capability_i & ~sec_n,
                                      code_q,
                                      rreq_flag_q,
                                      schg_flag_q,
                                      ~sb_n,
                                      ~usb_n};
      assign ff_w[3*b +: 3]    = ff_q;
      assign state_w[3*b +: 3] = code_q;
      assign alert_w[b]        = alert_q;
      assign alert_d_w[b]      = alert_d;
      assign pwr_w[b]          = pwr_q;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // alert pin
  // --------------------------------------------------------------------------
  // built from next-state terms, so the flop adds no cycle of latency
  reg        alert_out_q;

  always @(posedge clk_i) begin
    if (reset_i) begin
      alert_out_q <= 1'b0;
    end else begin
      alert_out_q <= |alert_d_w;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign power_enable_out_o     = pwr_w;
  assign alert_out_o            = alert_out_q;
  assign actual_slot_state_b0_o = state_w[2:0];
  assign actual_slot_state_b1_o = state_w[5:3];
  assign actual_slot_state0_o   = {pwr_w[0], alert_w[0]};

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  reg [7:0] rdata_d;

  // unmapped and reserved bytes read zero
  always @* begin
    rdata_d = 8'h00;
    if (reg_addr_i == `BCS_SLOT0_CONTROL_OFS) begin
      rdata_d = ctrl_byte_w[7:0];
    end else if (reg_addr_i == `BCS_SLOT1_CONTROL_OFS) begin
      rdata_d = ctrl_byte_w[15:8];
    end else if (reg_addr_i == `BCS_SLOT0_STATUS_OFS) begin
      rdata_d = stat_byte_w[7:0];
    end else if (reg_addr_i == `BCS_SLOT0_STATUS_OFS + 8'h01) begin
      rdata_d = {5'h00, ff_w[2:0]};
    end else if (reg_addr_i == `BCS_SLOT1_STATUS_OFS) begin
      rdata_d = stat_byte_w[15:8];
    end else if (reg_addr_i == `BCS_SLOT1_STATUS_OFS + 8'h01) begin
      rdata_d = {5'h00, ff_w[5:3]};
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

endmodule // bcs_bank

/* File: bcs_regs.vh */
// register offsets, field positions, codes and reset values for the slot control/status bank
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// ----------------------------------------------------------------------------
// byte offsets of the register words
// ----------------------------------------------------------------------------
`define BCS_SLOT0_CONTROL_OFS   8'h10
`define BCS_SLOT1_CONTROL_OFS   8'h18
`define BCS_SLOT0_STATUS_OFS    8'h14
`define BCS_SLOT1_STATUS_OFS    8'h20

// ----------------------------------------------------------------------------
// control register fields (byte 0)
// ----------------------------------------------------------------------------
`define BCS_CTL_LOCK_BIT        7
`define BCS_CTL_REQ_HI          6
`define BCS_CTL_REQ_LO          4
`define BCS_CTL_RREQ_EN_BIT     3
`define BCS_CTL_SCHG_EN_BIT     2
`define BCS_CTL_WAKE_EN_BIT     1
`define BCS_CTL_PWR_BIT         0

// ----------------------------------------------------------------------------
// status register fields (byte 0, form factor in byte 1)
// ----------------------------------------------------------------------------
`define BCS_STS_SEC_BIT         7
`define BCS_STS_STATE_HI        6
`define BCS_STS_STATE_LO        4
`define BCS_STS_RREQ_BIT        3
`define BCS_STS_SCHG_BIT        2
`define BCS_STS_SBPRS_BIT       1
`define BCS_STS_USBPRS_BIT      0
`define BCS_STS_FF_HI           2
`define BCS_STS_FF_LO           0

// ----------------------------------------------------------------------------
// slot state codes
// ----------------------------------------------------------------------------
`define BCS_ST_EMPTY            3'h0
`define BCS_ST_INSERTED         3'h1
`define BCS_ST_ENABLED          3'h2
`define BCS_ST_REM_REQUESTED    3'h3
`define BCS_ST_REM_ALLOWED      3'h4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define BCS_CONTROL_RST         8'h00
`define BCS_STATE_RST           3'h0
`define BCS_FF_POR              3'h0
`define BCS_PIN_IDLE            8'hff

`endif

/* File: bcs_sync.v */
// two flip-flop synchroniser for the asynchronous slot pins
`timescale 1ns/1ps

module bcs_sync #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire         reset_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);

  reg [W-1:0] meta_q;

  // pins idle high (pulled up), so reset to the inactive level
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= {W{1'b1}};
      sync_o <= {W{1'b1}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // bcs_sync

/* File: bcs_bay_model.sv */
// behavioural device bay: presence, removal button and security lock pins per slot
`timescale 1ns/1ps

module bcs_bay_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] usb_fitted_i,
  input  wire logic [1:0] sb_fitted_i,
  input  wire logic [1:0] button_i,
  input  wire logic [1:0] locked_i,
  output logic      [1:0] usb_present_n_o,
  output logic      [1:0] sb_present_n_o,
  output logic      [1:0] removal_request_n_o,
  output logic      [1:0] security_lock_n_o
);
  // pins carry pull-ups, so an empty bay reads high rather than a stale level
  initial begin
    usb_present_n_o     = 2'b11;
    sb_present_n_o      = 2'b11;
    removal_request_n_o = 2'b11;
    security_lock_n_o   = 2'b11;
  end

  always @(posedge clk_i) begin
    usb_present_n_o     <= ~usb_fitted_i;
    sb_present_n_o      <= ~sb_fitted_i;
    removal_request_n_o <= ~button_i;
    security_lock_n_o   <= ~locked_i;
  end
endmodule // bcs_bay_model

/* File: bcs_bank_checker.sv */
// port-level assertions for the slot control/status bank
`timescale 1ns/1ps

module bcs_bank_checker (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       power_on_reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       security_capability_i,
  input wire logic [1:0] serial_bus_present_in_n_i,
  input wire logic [1:0] usb_present_in_n_i,
  input wire logic [1:0] removal_request_in_n_i,
  input wire logic [1:0] security_lock_in_n_i,
  input wire logic [1:0] power_enable_out_o,
  input wire logic [1:0] actual_slot_state0_o,
  input wire logic [2:0] actual_slot_state_b0_o,
  input wire logic [2:0] actual_slot_state_b1_o,
  input wire logic       alert_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ----
  // sequences
  // ----
  sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
  // pins pass two sync flops, so only a settled pin may be compared with a read
  sequence s_quiet; $stable({security_capability_i, security_lock_in_n_i, serial_bus_present_in_n_i,
                             usb_present_in_n_i})[*4]; endsequence
  sequence s_gone(sb, us); (sb && us)[*5]; endsequence

  property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
  property p_rvalid_src; reg_rvalid_o |-> $past(reg_rd_i); endproperty
  property p_unmapped; s_rd(8'h30) |=> reg_rdata_o == 8'h00; endproperty
  property p_pwr(b, a);
    $rose(power_enable_out_o[b]) |-> $past(reg_wr_i && reg_addr_i == a && reg_wdata_i[7] && reg_wdata_i[0]);
  endproperty
  property p_gone0; s_gone(serial_bus_present_in_n_i[0], usb_present_in_n_i[0]) |->
    !power_enable_out_o[0] && actual_slot_state_b0_o == 3'h0; endproperty
  property p_gone1; s_gone(serial_bus_present_in_n_i[1], usb_present_in_n_i[1]) |->
    !power_enable_out_o[1] && actual_slot_state_b1_o == 3'h0; endproperty
  // a slot0 alert term may only rise after a register write or a slot0 pin change three edges back
  property p_alert; $rose(actual_slot_state0_o[0]) |-> alert_out_o && ($past(reg_wr_i) ||
    $past({removal_request_in_n_i[0], usb_present_in_n_i[0], serial_bus_present_in_n_i[0]}, 3) !=
    $past({removal_request_in_n_i[0], usb_present_in_n_i[0], serial_bus_present_in_n_i[0]}, 4)); endproperty
  property p_state; actual_slot_state_b0_o <= 3'h4 && actual_slot_state_b1_o <= 3'h4; endproperty
  property p_pins; s_quiet ##0 s_rd(8'h14) |=> reg_rdata_o[7] == $past(security_capability_i &&
    !security_lock_in_n_i[0]) && reg_rdata_o[1:0] == ~$past({serial_bus_present_in_n_i[0],
    usb_present_in_n_i[0]}); endproperty

  a_rvalid:     assert property (p_rvalid) else $error("read strobe not answered");
  a_rvalid_src: assert property (p_rvalid_src) else $error("valid without read");
  a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
  a_pwr0:       assert property (p_pwr(0, 8'h10)) else $error("slot0 power on without lock write");
  a_pwr1:       assert property (p_pwr(1, 8'h18)) else $error("slot1 power on without lock write");
  a_gone0:      assert property (p_gone0) else $error("slot0 not empty after removal");
  a_gone1:      assert property (p_gone1) else $error("slot1 not empty after removal");
  a_alert:      assert property (p_alert) else $error("slot0 alert without cause or pin");
  a_state:      assert property (p_state) else $error("reserved slot state");
  a_pins:       assert property (p_pins) else $error("status pin bits wrong");
endmodule // bcs_bank_checker

bind bcs_bank bcs_bank_checker bcs_bank_checker_inst (.clk_i, .reset_i, .power_on_reset_i, .reg_addr_i,
  .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .security_capability_i,
  .serial_bus_present_in_n_i, .usb_present_in_n_i, .removal_request_in_n_i, .security_lock_in_n_i,
  .power_enable_out_o, .actual_slot_state0_o, .actual_slot_state_b0_o, .actual_slot_state_b1_o, .alert_out_o);

/* File: tb.sv */
// self-checking bench for the slot control/status bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  logic       clk_i = 1'b0, reset_i = 1'b1, power_on_reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rvalid_o, alert_out_o;
  logic       security_capability_i = 1'b0;
  logic [1:0] usb_fit = 2'b00, sb_fit = 2'b00, button = 2'b00, locked = 2'b00;
  logic [1:0] serial_bus_present_in_n_i, usb_present_in_n_i, removal_request_in_n_i, security_lock_in_n_i;
  logic [1:0] power_enable_out_o, actual_slot_state0_o;
  logic [2:0] actual_slot_state_b0_o, actual_slot_state_b1_o;
  int         failures = 0, total_checks = 0;

  always #50 clk_i = ~clk_i;

  bcs_bank bcs_bank_inst (.clk_i, .reset_i, .power_on_reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .security_capability_i, .serial_bus_present_in_n_i,
    .usb_present_in_n_i, .removal_request_in_n_i, .security_lock_in_n_i, .power_enable_out_o,
    .actual_slot_state0_o, .actual_slot_state_b0_o, .actual_slot_state_b1_o, .alert_out_o);

  bcs_bay_model bcs_bay_model_inst (.clk_i, .usb_fitted_i(usb_fit), .sb_fitted_i(sb_fit),
    .button_i(button), .locked_i(locked), .usb_present_n_o(usb_present_in_n_i),
    .sb_present_n_o(serial_bus_present_in_n_i), .removal_request_n_o(removal_request_in_n_i),
    .security_lock_n_o(security_lock_in_n_i));

  task automatic summarize;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    `CHK(reg_rvalid_o, 1'b1)
    `CHK(reg_rdata_o, e)
  endtask

  // hang guard: the sequence below needs well under 400 cycles
  initial begin
    idle(2000);
    failures++;
    summarize();
  end

  initial begin
    idle(8);
    reset_i          <= 1'b0;
    power_on_reset_i <= 1'b0;
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h30, 8'h00);
    wr(8'h15, 8'h01);
    wr(8'h15, 8'h02);
    rd_chk(8'h15, 8'h01);
    @(posedge clk_i) reset_i <= 1'b1;
    @(posedge clk_i) reset_i <= 1'b0;
    rd_chk(8'h15, 8'h01);
    wr(8'h10, 8'h81);
    rd_chk(8'h10, 8'h80);
    wr(8'h10, 8'h04);
    @(posedge clk_i) usb_fit <= 2'b01;
    idle(6);
    rd_chk(8'h14, 8'h15);
    `CHK(alert_out_o, 1'b1)
    `CHK(actual_slot_state0_o, 2'b01)
    `CHK(actual_slot_state_b0_o, 3'h1)
    wr(8'h14, 8'h04);
    rd_chk(8'h14, 8'h11);
    wr(8'h10, 8'h05);
    rd_chk(8'h10, 8'h04);
    wr(8'h10, 8'h85);
    rd_chk(8'h10, 8'h85);
    `CHK(power_enable_out_o, 2'b01)
    wr(8'h10, 8'ha5);
    wr(8'h10, 8'h85);
    rd_chk(8'h10, 8'ha5);
    rd_chk(8'h14, 8'h21);
    `CHK(actual_slot_state_b0_o, 3'h2)
    @(posedge clk_i) button <= 2'b01;
    idle(6);
    rd_chk(8'h14, 8'h29);
    `CHK(alert_out_o, 1'b0)
    wr(8'h10, 8'h8d);
    rd_chk(8'h14, 8'h49);
    `CHK(alert_out_o, 1'b1)
    `CHK(actual_slot_state_b0_o, 3'h4)
    `CHK(actual_slot_state0_o, 2'b11)
    @(posedge clk_i) button <= 2'b00;
    wr(8'h14, 8'h08);
    @(posedge clk_i) usb_fit <= 2'b00;
    idle(6);
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h10, 8'h8c);
    `CHK(power_enable_out_o, 2'b00)
    @(posedge clk_i) begin
      security_capability_i <= 1'b1;
      locked                <= 2'b10;
      sb_fit                <= 2'b10;
    end
    idle(6);
    rd_chk(8'h20, 8'h86);
    `CHK(alert_out_o, 1'b0)
    `CHK(actual_slot_state_b0_o, 3'h0)
    `CHK(actual_slot_state_b1_o, 3'h0)
    @(posedge clk_i) power_on_reset_i <= 1'b1;
    @(posedge clk_i) power_on_reset_i <= 1'b0;
    wr(8'h21, 8'h02);
    rd_chk(8'h21, 8'h02);
    summarize();
  end
endmodule // tb
